// >>> common/mdil_pkg.sv
// Purpose: Shared constants and types for the motor driver input logic
// Assumes: 250 MHz clock, AHB-Lite register access, 32-bit data
// Notes: Register map, field positions, reset values and timing counts
package mdil_pkg;
   localparam int unsigned MDIL_NUM_IN = 9;
   localparam int unsigned MDIL_CLK_KHZ = 250000;
   localparam int unsigned MDIL_MIN_PULSE_MS = 10;
   localparam int unsigned MDIL_MIN_PULSE_CYC = MDIL_MIN_PULSE_MS * MDIL_CLK_KHZ;
   localparam int unsigned MDIL_CNT_W = 22;

   localparam logic [7:0] MDIL_OFS_CTRL = 8'h00;
   localparam logic [7:0] MDIL_OFS_POL = 8'h04;
   localparam logic [7:0] MDIL_OFS_FUNC_LO = 8'h08;
   localparam logic [7:0] MDIL_OFS_FUNC_HI = 8'h0c;
   localparam logic [7:0] MDIL_OFS_STATUS = 8'h10;
   localparam logic [7:0] MDIL_OFS_SPEED = 8'h40;
   localparam logic [1:0] MDIL_SPEED_BANK = 2'h1;

   localparam int unsigned MDIL_CTRL_MODE_BIT = 0;
   localparam int unsigned MDIL_CTRL_DIR_BIT = 1;
   localparam int unsigned MDIL_ST_DN_LSB = 9;
   localparam int unsigned MDIL_ST_MS_LSB = 13;
   localparam int unsigned MDIL_ST_DIR_BIT = 15;

   localparam logic MDIL_MODE_RST = 1'b0;
   localparam logic MDIL_DIR_RST = 1'b1;
   localparam logic [8:0] MDIL_POL_RST = 9'h000;

   typedef enum logic [3:0] {
      FN_NONE = 4'h0,
      FN_FWD = 4'h1,
      FN_RVS = 4'h2,
      FN_M0 = 4'h3,
      FN_M1 = 4'h4,
      FN_M2 = 4'h5,
      FN_M3 = 4'h6,
      FN_START = 4'h7,
      FN_HOME = 4'h8
   } mdil_func_t;

   localparam logic [8:0][3:0] MDIL_FUNC_RST = {FN_NONE, FN_NONE, FN_NONE, FN_M3, FN_M2,
      FN_M1, FN_M0, FN_RVS, FN_FWD};

   typedef enum logic [1:0] {
      MS_IDLE = 2'b00,
      MS_RUN_F = 2'b01,
      MS_RUN_R = 2'b10,
      MS_DECEL = 2'b11
   } mdil_ms_t;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } mdil_ahb_in_t;

   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } mdil_ahb_out_t;

   typedef struct packed {
      logic run;
      logic decel;
      logic dir_cw;
      logic [15:0] speed;
      logic [3:0] data_no;
      logic start_cmd;
      logic home_cmd;
   } mdil_motion_t;
endpackage

// >>> design/mdil_input_logic.sv
// Purpose: Input terminal logic of a brushless motor driver
// Assumes: Pins are raw levels; motor_stopped comes from same-clock logic
// Notes: Registers over AHB-Lite, zero wait states, always OKAY
// Overview of operation
// - Current flowing means input asserted
// - Per-terminal polarity, 1 inverts, default 0
// - Four select inputs form data number
// - Speed mode runs at selected data speed
// - Speed mode release decelerates to stop
// - Direction setting maps positive to forward_run_cmd/CW
// - Position mode forward positive, reverse negative
// - Both or neither command decelerates
// - Same command during decel re-accelerates
// - Only mode-legal functions take effect
`timescale 1ns/10ps
`default_nettype none
module mdil_input_logic #(
   parameter int unsigned MIN_PULSE_CYC = mdil_pkg::MDIL_MIN_PULSE_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [8:0] general_input_terminals,
   input wire logic motor_stopped,
   input wire mdil_pkg::mdil_ahb_in_t ahb_in,
   output mdil_pkg::mdil_ahb_out_t ahb_out,
   output mdil_pkg::mdil_motion_t motion
);
   import mdil_pkg::*;

   typedef struct packed {
      logic [8:0] sync1;
      logic [8:0] sync2;
      logic [8:0] filt;
      logic [8:0][MDIL_CNT_W-1:0] cnt;
      logic mode;
      logic dir_set;
      logic [8:0] pol;
      logic [8:0][3:0] func;
      logic [15:0][15:0] spd;
      mdil_ms_t ms;
      logic last_f;
      logic dir_cw;
      logic [15:0] speed;
      logic [3:0] data_no;
      logic act_q;
      logic wr_q;
      logic hi_ok_q;
      logic [7:0] addr_q;
      logic [31:0] rdata;
   } mdil_st_t;

   localparam logic [MDIL_CNT_W-1:0] MIN_M1 = MDIL_CNT_W'(MIN_PULSE_CYC - 1);

   mdil_st_t st_r;
   mdil_st_t st_nxt;
   logic [8:0] inv_in;
   logic forward_run_cmd;
   logic reverse_run_cmd;
   logic fwd_only;
   logic rvs_only;

   // Function legal in the given control mode
   function automatic logic fn_allowed(input logic [3:0] code, input logic mode);
      fn_allowed = (code < FN_START) || mode;
   endfunction

   // Any terminal carrying this function is active
   function automatic logic fn_active(input logic [8:0][3:0] func, input logic [8:0] lvl,
      input logic mode, input logic [3:0] code);
      fn_active = 1'b0;
      for (int i = 0; i < MDIL_NUM_IN; i++) begin
         if (lvl[i] && func[i] == code && fn_allowed(code, mode)) begin
            fn_active = 1'b1;
         end
      end
   endfunction

   // Inversion sits ahead of the filter and decode
   assign inv_in = st_r.sync2 ^ st_r.pol;
   assign forward_run_cmd = fn_active(st_r.func, st_r.filt, st_r.mode, FN_FWD);
   assign reverse_run_cmd = fn_active(st_r.func, st_r.filt, st_r.mode, FN_RVS);
   assign fwd_only = forward_run_cmd && !reverse_run_cmd;
   assign rvs_only = reverse_run_cmd && !forward_run_cmd;

   always_comb begin
      st_nxt = st_r;
      // Input pins: high means current in the isolated stage
      st_nxt.sync1 = general_input_terminals;
      st_nxt.sync2 = st_r.sync1;
      for (int i = 0; i < MDIL_NUM_IN; i++) begin
         if (inv_in[i] == st_r.filt[i]) begin
            st_nxt.cnt[i] = '0;
         end else if (st_r.cnt[i] >= MIN_M1) begin
            st_nxt.filt[i] = inv_in[i];
            st_nxt.cnt[i] = '0;
         end else begin
            st_nxt.cnt[i] = st_r.cnt[i] + 1'b1;
         end
      end

      st_nxt.data_no = {fn_active(st_r.func, st_r.filt, st_r.mode, FN_M3),
         fn_active(st_r.func, st_r.filt, st_r.mode, FN_M2),
         fn_active(st_r.func, st_r.filt, st_r.mode, FN_M1),
         fn_active(st_r.func, st_r.filt, st_r.mode, FN_M0)};
      st_nxt.speed = st_r.spd[st_r.data_no];

      case (st_r.ms)
         MS_IDLE: begin
            if (fwd_only) begin
               st_nxt.ms = MS_RUN_F;
            end else if (rvs_only) begin
               st_nxt.ms = MS_RUN_R;
            end
         end
         MS_RUN_F: begin
            if (!fwd_only) begin
               st_nxt.ms = MS_DECEL;
               st_nxt.last_f = 1'b1;
            end
         end
         MS_RUN_R: begin
            if (!rvs_only) begin
               st_nxt.ms = MS_DECEL;
               st_nxt.last_f = 1'b0;
            end
         end
         MS_DECEL: begin
            if (st_r.last_f && fwd_only) begin
               st_nxt.ms = MS_RUN_F;
            end else if (!st_r.last_f && rvs_only) begin
               st_nxt.ms = MS_RUN_R;
            end else if (motor_stopped) begin
               st_nxt.ms = MS_IDLE;
            end
         end
         default: begin
            st_nxt.ms = MS_IDLE;
         end
      endcase
      if (st_nxt.ms == MS_RUN_F) begin
         st_nxt.dir_cw = st_r.dir_set;
      end else if (st_nxt.ms == MS_RUN_R) begin
         st_nxt.dir_cw = !st_r.dir_set;
      end

      // Data phase write
      if (st_r.act_q && st_r.wr_q && st_r.hi_ok_q) begin
         if (st_r.addr_q[7:6] == MDIL_SPEED_BANK && st_r.addr_q[1:0] == 2'h0) begin
            st_nxt.spd[st_r.addr_q[5:2]] = ahb_in.hwdata[15:0];
         end else begin
            case (st_r.addr_q)
               MDIL_OFS_CTRL: begin
                  st_nxt.mode = ahb_in.hwdata[MDIL_CTRL_MODE_BIT];
                  st_nxt.dir_set = ahb_in.hwdata[MDIL_CTRL_DIR_BIT];
               end
               MDIL_OFS_POL: begin
                  st_nxt.pol = ahb_in.hwdata[8:0];
               end
               MDIL_OFS_FUNC_LO: begin
                  st_nxt.func[7:0] = ahb_in.hwdata;
               end
               MDIL_OFS_FUNC_HI: begin
                  st_nxt.func[8] = ahb_in.hwdata[3:0];
               end
               default: begin
               end
            endcase
         end
      end

      // Address phase capture; read word reflects a write just completed
      st_nxt.act_q = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
      if (st_nxt.act_q) begin
         st_nxt.wr_q = ahb_in.hwrite;
         st_nxt.addr_q = ahb_in.haddr[7:0];
         st_nxt.hi_ok_q = ahb_in.haddr[31:8] == 24'h000000;
         st_nxt.rdata = '0;
         if (!st_nxt.hi_ok_q || ahb_in.hwrite) begin
            st_nxt.rdata = '0;
         end else if (ahb_in.haddr[7:6] == MDIL_SPEED_BANK && ahb_in.haddr[1:0] == 2'h0) begin
            st_nxt.rdata[15:0] = st_nxt.spd[ahb_in.haddr[5:2]];
         end else begin
            case (ahb_in.haddr[7:0])
               MDIL_OFS_CTRL: begin
                  st_nxt.rdata[MDIL_CTRL_MODE_BIT] = st_nxt.mode;
                  st_nxt.rdata[MDIL_CTRL_DIR_BIT] = st_nxt.dir_set;
               end
               MDIL_OFS_POL: begin
                  st_nxt.rdata[8:0] = st_nxt.pol;
               end
               MDIL_OFS_FUNC_LO: begin
                  st_nxt.rdata = st_nxt.func[7:0];
               end
               MDIL_OFS_FUNC_HI: begin
                  st_nxt.rdata[3:0] = st_nxt.func[8];
               end
               MDIL_OFS_STATUS: begin
                  st_nxt.rdata[8:0] = st_r.filt;
                  st_nxt.rdata[MDIL_ST_DN_LSB +: 4] = st_r.data_no;
                  st_nxt.rdata[MDIL_ST_MS_LSB +: 2] = st_r.ms;
                  st_nxt.rdata[MDIL_ST_DIR_BIT] = st_r.dir_cw;
               end
               default: begin
               end
            endcase
         end
      end

      if (rst) begin
         st_nxt = '0;
         st_nxt.mode = MDIL_MODE_RST;
         st_nxt.dir_set = MDIL_DIR_RST;
         st_nxt.dir_cw = MDIL_DIR_RST;
         st_nxt.pol = MDIL_POL_RST;
         st_nxt.func = MDIL_FUNC_RST;
         st_nxt.ms = MS_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      st_r <= st_nxt;
   end

   assign ahb_out.hreadyout = 1'b1;
   assign ahb_out.hresp = 1'b0;
   assign ahb_out.hrdata = st_r.rdata;

   assign motion.run = st_r.ms == MS_RUN_F || st_r.ms == MS_RUN_R;
   assign motion.decel = st_r.ms == MS_DECEL;
   assign motion.dir_cw = st_r.dir_cw;
   assign motion.speed = st_r.speed;
   assign motion.data_no = st_r.data_no;
   // Position-only functions gated by mode
   assign motion.start_cmd = fn_active(st_r.func, st_r.filt, st_r.mode, FN_START);
   assign motion.home_cmd = fn_active(st_r.func, st_r.filt, st_r.mode, FN_HOME);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_filter_wait: assert property ($changed(st_r.filt[0]) |-> $past(st_r.cnt[0]) == MIN_M1)
      else $error("terminal 0 changed before minimum pulse");

   a_polarity_path: assert property ((st_r.cnt[1] == '0 && $past(st_r.cnt[1]) == '0 &&
      $stable(st_r.pol[1]) && $stable(st_r.sync2[1])) |-> st_r.filt[1] == inv_in[1])
      else $error("filtered level disagrees with polarity");

   a_data_number: assert property (##1 st_r.data_no == {$past(fn_active(st_r.func,
      st_r.filt, st_r.mode, FN_M3)), $past(fn_active(st_r.func, st_r.filt, st_r.mode,
      FN_M2)), $past(fn_active(st_r.func, st_r.filt, st_r.mode, FN_M1)),
      $past(fn_active(st_r.func, st_r.filt, st_r.mode, FN_M0))})
      else $error("data number not formed from select bits");

   a_speed_select: assert property (motion.run && $past(motion.run) |->
      motion.speed == $past(st_r.spd[st_r.data_no]))
      else $error("run speed not from selected entry");

   a_speed_release: assert property ((!st_r.mode && st_r.ms == MS_RUN_F && !forward_run_cmd) |=>
      st_r.ms == MS_DECEL && st_r.last_f)
      else $error("release did not decelerate");

   a_dir_map: assert property ((st_r.ms == MS_RUN_F && $stable(st_r.dir_set) &&
      $past(st_r.ms) == MS_RUN_F) |-> motion.dir_cw == st_r.dir_set)
      else $error("forward direction mapping wrong");

   a_pos_start: assert property ((st_r.mode && st_r.ms == MS_IDLE && rvs_only) |=>
      st_r.ms == MS_RUN_R ##0 motion.dir_cw == !$past(st_r.dir_set))
      else $error("reverse start wrong");

   a_both_stop: assert property ((st_r.mode && motion.run && forward_run_cmd == reverse_run_cmd) |=>
      st_r.ms == MS_DECEL)
      else $error("both or neither did not decelerate");

   a_reaccel: assert property ((st_r.ms == MS_DECEL && st_r.last_f && fwd_only) |=>
      st_r.ms == MS_RUN_F)
      else $error("no re-acceleration on same command");

   a_mode_gate: assert property (!st_r.mode |-> !motion.start_cmd && !motion.home_cmd)
      else $error("position function active in speed mode");
endmodule
`default_nettype wire

// >>> test/mdil_ctrl_model.sv
// Purpose: Controller model driving the nine terminals
// Assumes: want is the requested level, 1 = current flows
// Notes: glitch lays a commanded short pulse over the held level
`timescale 1ns/10ps
`default_nettype none
module mdil_ctrl_model #(
   parameter int unsigned HOLD = 6
) (
   input wire logic clk,
   input wire logic [8:0] want,
   input wire logic [8:0] glitch,
   output logic [8:0] pins
);
   logic [8:0] held_r = 9'h000;
   int unsigned cnt_r = HOLD;
   // Each level held at least HOLD cycles
   always @(posedge clk) begin
      if (cnt_r < HOLD) begin
         cnt_r <= cnt_r + 1;
      end else if (want !== held_r) begin
         held_r <= want;
         cnt_r <= 0;
      end
   end
   // High level means current flows
   assign pins = held_r ^ glitch;
endmodule
`default_nettype wire

// >>> test/motor_driver_input_logic_bench.sv
// Purpose: Self-checking bench for the motor driver input logic
// Assumes: Filter shortened to MIN cycles; settle covers its latency
// Notes: Fixed seed; speed table filled at random
`timescale 1ns/10ps
`default_nettype none
module motor_driver_input_logic_bench;
   import mdil_pkg::*;
   localparam int unsigned MIN = 4;
   logic clk, rst, motor_stopped;
   logic [8:0] want, glitch, pins;
   mdil_ahb_in_t ahb_in;
   mdil_ahb_out_t ahb_out;
   mdil_motion_t motion;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic [15:0] spd [16];
   logic [3:0] n;
   mdil_input_logic #(.MIN_PULSE_CYC(MIN)) dut (.clk(clk), .rst(rst),
      .general_input_terminals(pins), .motor_stopped(motor_stopped),
      .ahb_in(ahb_in), .ahb_out(ahb_out), .motion(motion));
   mdil_ctrl_model #(.HOLD(MIN + 2)) ctrl (.clk(clk), .want(want),
      .glitch(glitch), .pins(pins));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @* ahb_in.hready = ahb_out.hreadyout;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt = error_cnt + 1;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      ahb_in.hsel <= 1'b1;
      ahb_in.haddr <= {24'h0, a};
      ahb_in.htrans <= 2'h2;
      ahb_in.hwrite <= wr;
      do @(posedge clk); while (ahb_out.hreadyout !== 1'b1);
      ahb_in.htrans <= 2'h0;
      ahb_in.hwdata <= wd;
      do @(posedge clk); while (ahb_out.hreadyout !== 1'b1);
      rd = ahb_out.hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk({31'h0, ahb_out.hresp}, 32'h0);
      chk(rd, exp);
   endtask
   task automatic settle();
      repeat (24) @(posedge clk);
   endtask
   task automatic mchk(input logic [1:0] e);
      chk({30'h0, motion.run, motion.decel}, {30'h0, e});
   endtask
   task automatic stop_motor();
      motor_stopped <= 1'b1;
      repeat (3) @(posedge clk);
      motor_stopped <= 1'b0;
      @(posedge clk);
      mchk(2'b00);
   endtask
   function automatic logic [31:0] st(logic [8:0] f, logic [3:0] d, logic [1:0] s, logic c);
      return {16'h0, c, s, d, f};
   endfunction
   initial begin
      rst = 1'b1;
      motor_stopped = 1'b0;
      want = 9'h0;
      glitch = 9'h0;
      ahb_in = '{hsize: 3'h2, hready: 1'b1, default: '0};
      void'($urandom(37468));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdchk(MDIL_OFS_CTRL, 32'h2);
      rdchk(MDIL_OFS_POL, 32'h0);
      rdchk(MDIL_OFS_FUNC_LO, 32'h00654321);
      rdchk(MDIL_OFS_FUNC_HI, 32'h0);
      rdchk(MDIL_OFS_STATUS, st(9'h0, 4'h0, 2'h0, 1'b1));
      bus(1'b1, 8'h20, 32'hffffffff);
      rdchk(8'h20, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         spd[i] = 16'($urandom);
         bus(1'b1, MDIL_OFS_SPEED + 8'(4 * i), {16'h0, spd[i]});
      end
      for (int i = 0; i < 10; i++) begin
         n = (i < 2) ? 4'(15 * i) : 4'($urandom);
         want <= {3'h0, n, 2'h0};
         settle();
         chk({28'h0, motion.data_no}, {28'h0, n});
         chk({16'h0, motion.speed}, {16'h0, spd[n]});
         rdchk(MDIL_OFS_STATUS, st({3'h0, n, 2'h0}, n, 2'h0, 1'b1));
      end
      $display("test data number done");
      want <= {3'h0, n, 2'h1};
      settle();
      mchk(2'b10);
      chk({31'h0, motion.dir_cw}, 32'h1);
      chk({16'h0, motion.speed}, {16'h0, spd[n]});
      want <= {3'h0, n, 2'h0};
      settle();
      mchk(2'b01);
      stop_motor();
      $display("test speed mode done");
      bus(1'b1, MDIL_OFS_CTRL, 32'h1);
      want <= 9'h001;
      settle();
      mchk(2'b10);
      chk({31'h0, motion.dir_cw}, 32'h0);
      want <= 9'h000;
      settle();
      mchk(2'b01);
      want <= 9'h001;
      settle();
      mchk(2'b10);
      want <= 9'h003;
      settle();
      mchk(2'b01);
      want <= 9'h000;
      settle();
      stop_motor();
      want <= 9'h002;
      settle();
      mchk(2'b10);
      chk({31'h0, motion.dir_cw}, 32'h1);
      want <= 9'h000;
      settle();
      stop_motor();
      $display("test position mode done");
      bus(1'b1, MDIL_OFS_POL, 32'h1);
      settle();
      mchk(2'b10);
      rdchk(MDIL_OFS_STATUS, st(9'h1, 4'h0, 2'h1, 1'b0));
      bus(1'b1, MDIL_OFS_POL, 32'h0);
      settle();
      stop_motor();
      glitch <= 9'h001;
      repeat (MIN - 2) @(posedge clk);
      glitch <= 9'h000;
      settle();
      mchk(2'b00);
      $display("test polarity and filter done");
      bus(1'b1, MDIL_OFS_FUNC_LO, 32'h87654321);
      bus(1'b1, MDIL_OFS_CTRL, 32'h2);
      want <= 9'h0c0;
      settle();
      chk({30'h0, motion.start_cmd, motion.home_cmd}, 32'h0);
      bus(1'b1, MDIL_OFS_CTRL, 32'h3);
      @(posedge clk);
      chk({30'h0, motion.start_cmd, motion.home_cmd}, 32'h3);
      $display("test mode functions done");
      complete_run();
   end
endmodule
`default_nettype wire
